// ---- design/reload_timer.sv ----
/*
 reloadable 16-bit up-counting timer: one-shot, continuous, counter modes.
 assumes hclk at 100 MHz, tmr_in an asynchronous pin, AHB-Lite master outside.
*/
`timescale 1ns/100ps
`default_nettype none
module reload_timer
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tmr_in,
  output logic tmr_out,
  output logic tmr_out_oe,
  output logic timer_irq
);
  timer_cfg_if cfg ();

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic in_prev;
    logic [15:0] count;
    logic out_level;
    logic irq;
  } core_s;
  core_s state;
  core_s next_state;
  logic tick;
  logic edge_hit;
  logic advance;
  logic at_reload;
  logic reload_evt;
  logic presc_clear;

  timer_ahb_regs timer_ahb_regs_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .cfg(cfg.regs)
  );

  // counter mode bypasses the divider, so keep it parked there
  assign presc_clear = !cfg.enable || (cfg.mode == mode_counter);

  timer_prescaler timer_prescaler_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(presc_clear),
    .sel(cfg.presc_sel),
    .tick(tick)
  );

  // edges come from the two later samples, never from sync1
  assign edge_hit = cfg.output_polarity ? (state.sync2 && !state.in_prev)
                                        : (!state.sync2 && state.in_prev);
  assign advance = cfg.enable && ((cfg.mode == mode_counter) ? edge_hit : tick);
  assign at_reload = (state.count == cfg.reload);
  assign reload_evt = advance && at_reload;

  assign cfg.count = state.count;
  assign cfg.reload_event = state.irq;
  assign cfg.auto_disable = reload_evt && (cfg.mode == mode_one_shot);
  assign timer_irq = state.irq;
  assign tmr_out = state.out_level;
  assign tmr_out_oe = cfg.out_enable;

  always_comb begin
    next_state = state;
    next_state.sync1 = tmr_in;
    next_state.sync2 = state.sync1;
    next_state.in_prev = state.sync2;
    next_state.irq = reload_evt;
    if (!cfg.enable) begin
      // idle level follows polarity; a flip made during a one-shot only shows after time-out
      next_state.out_level = cfg.output_polarity;
    end
    if (cfg.count_wr) begin
      next_state.count = cfg.count_wdata;
    end else if (reload_evt) begin
      next_state.count = count_restart;
      // one-shot disables next cycle, which snaps the level back: a one-cycle pulse
      next_state.out_level = state.out_level ^ cfg.out_enable;
    end else if (advance) begin
      // reload 0000H falls through here: full span then wrap
      next_state.count = state.count + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  a_wrap_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    advance && !cfg.count_wr && !at_reload && state.count == 16'hffff
    |=> state.count == 16'h0000) else $error("count did not wrap");
  a_reload_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    reload_evt && !cfg.count_wr |=> state.count == count_restart && timer_irq)
    else $error("reload did not restart");
  a_oneshot_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    reload_evt && cfg.mode == mode_one_shot |=> !cfg.enable)
    else $error("one-shot kept running");
  a_oneshot_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    reload_evt && cfg.mode == mode_one_shot && cfg.out_enable && !cfg.count_wr
    && tmr_out == cfg.output_polarity
    |=> tmr_out != $past(tmr_out) ##1 tmr_out == cfg.output_polarity)
    else $error("pulse not one cycle");
  a_oneshot_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg.enable && cfg.mode == mode_one_shot && !reload_evt |=> $stable(tmr_out))
    else $error("one-shot output moved before time-out");
  a_cont_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    reload_evt && cfg.mode == mode_continuous && cfg.out_enable && !cfg.count_wr
    |=> state.out_level != $past(state.out_level)) else $error("no toggle");
  a_counter_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg.enable && cfg.mode == mode_counter && !edge_hit && !cfg.count_wr
    |=> state.count == $past(state.count)) else $error("count moved without edge");
  a_counter_step: assert property (@(posedge hclk) disable iff (!hresetn)
    advance && cfg.mode == mode_counter && !at_reload && !cfg.count_wr
    |=> state.count == $past(state.count) + 16'h0001) else $error("step not one");
  a_tick_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && cfg.presc_sel != 3'h0 |=> !tick)
    else $error("divided prescale ticked twice");
  a_disabled_still: assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg.enable && !cfg.count_wr |=> state.count == $past(state.count))
    else $error("count moved while off");

  c_oneshot: cover property (@(posedge hclk) disable iff (!hresetn)
    reload_evt && cfg.mode == mode_one_shot);
  c_cont: cover property (@(posedge hclk) disable iff (!hresetn)
    reload_evt && cfg.mode == mode_continuous);
  c_counter: cover property (@(posedge hclk) disable iff (!hresetn)
    reload_evt && cfg.mode == mode_counter);
  c_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
    advance && state.count == 16'hffff && !at_reload);
endmodule : reload_timer
`default_nettype wire

// ---- design/timer_ahb_regs.sv ----
/*
 AHB-Lite slave holding control and reload registers, with access to the core's count and status.
 assumes single whole-word transfers; answers with zero wait states, always OKAY.
*/
`timescale 1ns/100ps
`default_nettype none
module timer_ahb_regs
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  timer_cfg_if.regs cfg
);
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] ctrl;
    logic [15:0] reload;
    logic [31:0] rdata;
  } regs_s;
  regs_s state;
  regs_s next_state;
  logic take;
  logic [7:0] ctrl_w;

  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state.rdata;
  assign cfg.enable = state.ctrl[ctrl_enable_bit];
  assign cfg.mode = state.ctrl[ctrl_mode_lsb +: 2];
  assign cfg.presc_sel = state.ctrl[ctrl_presc_lsb +: 3];
  assign cfg.output_polarity = state.ctrl[ctrl_pol_bit];
  assign cfg.out_enable = state.ctrl[ctrl_outen_bit];
  assign cfg.reload = state.reload;
  assign cfg.count_wr = state.wr_pend && (state.wr_addr == off_count);
  assign cfg.count_wdata = hwdata[15:0];

  always_comb begin
    next_state = state;
    ctrl_w = state.ctrl;
    if (cfg.auto_disable) begin
      ctrl_w[ctrl_enable_bit] = 1'b0;
    end
    if (state.wr_pend) begin
      unique case (state.wr_addr)
        off_ctrl: ctrl_w = hwdata[7:0];
        off_reload: next_state.reload = hwdata[15:0];
        default: ;
      endcase
    end
    next_state.ctrl = ctrl_w;
    next_state.wr_pend = take && hwrite;
    next_state.wr_addr = haddr[7:0];
    next_state.rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        off_ctrl: next_state.rdata = {24'h00_0000, ctrl_w};
        off_count: next_state.rdata = {16'h0000, cfg.count};
        off_reload: next_state.rdata = {16'h0000, state.reload};
        off_status: next_state.rdata = {31'h0000_0000, cfg.reload_event};
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  a_size_word: assert property (@(posedge hclk) disable iff (!hresetn)
    take |-> hsize == 3'h2) else $error("non-word access");
endmodule : timer_ahb_regs
`default_nettype wire

// ---- design/timer_cfg_if.sv ----
/*
 carrier between the register slave and the timer core.
 assumes both ends sit on hclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface timer_cfg_if;
  logic enable;
  logic [1:0] mode;
  logic [2:0] presc_sel;
  logic output_polarity;
  logic out_enable;
  logic [15:0] reload;
  logic count_wr;
  logic [15:0] count_wdata;
  logic [15:0] count;
  logic reload_event;
  logic auto_disable;
  modport regs (output enable, mode, presc_sel, output_polarity, out_enable, reload, count_wr,
    count_wdata, input count, reload_event, auto_disable);
  modport core (input enable, mode, presc_sel, output_polarity, out_enable, reload, count_wr,
    count_wdata, output count, reload_event, auto_disable);
endinterface : timer_cfg_if
`default_nettype wire

// ---- design/timer_pkg.sv ----
/*
 reloadable 16-bit timer: register map, field positions, reset values, modes.
 assumes a single 100 MHz system clock and an AHB-Lite register port.
*/
package timer_pkg;
  localparam int unsigned data_w = 16;
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_count = 8'h04;
  localparam logic [7:0] off_reload = 8'h08;
  localparam logic [7:0] off_status = 8'h0c;
  localparam int unsigned ctrl_enable_bit = 0;
  localparam int unsigned ctrl_mode_lsb = 1;
  localparam int unsigned ctrl_presc_lsb = 3;
  localparam int unsigned ctrl_pol_bit = 6;
  localparam int unsigned ctrl_outen_bit = 7;
  localparam logic [15:0] count_restart = 16'h0001;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] reload_reset = 16'h0000;
  localparam logic [2:0] presc_max_sel = 3'h7;
  typedef enum logic [1:0] {
    mode_one_shot = 2'h0,
    mode_continuous = 2'h1,
    mode_counter = 2'h2
  } timer_mode_e;
endpackage : timer_pkg

// ---- design/timer_prescaler.sv ----
/*
 power-of-two prescaler producing a one-cycle tick enable.
 assumes clear is held while the timer is disabled.
*/
`timescale 1ns/100ps
`default_nettype none
module timer_prescaler
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic [2:0] sel,
  output logic tick
);
  typedef struct packed {
    logic [6:0] div;
  } presc_s;
  presc_s state;
  presc_s next_state;
  logic [6:0] limit;

  assign limit = 7'((8'h01 << sel) - 8'h01);
  assign tick = !clear && (state.div == limit);

  always_comb begin
    next_state = state;
    if (clear || tick) begin
      next_state.div = 7'h00;
    end else begin
      next_state.div = state.div + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule : timer_prescaler
`default_nettype wire

// ---- tb/gpio_pin.sv ----
/*
 far-side pin model: an external event source driving the timer input.
 assumes the bench calls pulses() from its own process on hclk.
*/
`timescale 1ns/100ps
`default_nettype none
module gpio_pin (
  input wire logic hclk,
  output logic tmr_in
);
  initial tmr_in = 1'b0;
  // six clocks high and low keeps the pin well under a quarter of hclk
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge hclk);
      tmr_in <= 1'b1;
      repeat (6) @(posedge hclk);
      tmr_in <= 1'b0;
      repeat (6) @(posedge hclk);
    end
  endtask : pulses
endmodule : gpio_pin
`default_nettype wire

// ---- tb/reload_timer_tb.sv ----
/*
 self-checking bench for the reloadable timer: AHB-Lite register tasks, pin model.
 assumes a zero-wait-state slave and the control layout of timer_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module reload_timer_tb
  import timer_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, tmr_in, tmr_out, tmr_out_oe, timer_irq, hreadyout, hresp, lvl;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_errors = 0, checked = 0, cycles = 0, n_high = 0, n_irq = 0, n;
  logic [15:0] rl [4] = '{16'h0001, 16'h0005, 16'h0005, 16'h0002};
  logic [2:0] sl [4] = '{3'h0, 3'h0, 3'h3, 3'h7};

  reload_timer reload_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tmr_in(tmr_in), .tmr_out(tmr_out), .tmr_out_oe(tmr_out_oe), .timer_irq(timer_irq));
  gpio_pin gpio_pin_i (.hclk(hclk), .tmr_in(tmr_in));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles++;
    if (tmr_out === 1'b1) n_high++;
    if (timer_irq === 1'b1) n_irq++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // single transfer: address phase held until hready, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(name, exp, q);
  endtask : rd_chk

  // cycles from the last irq (or call) up to the next irq pulse
  task automatic wait_irq(output int k);
    k = 1;
    @(posedge hclk);
    while (timer_irq !== 1'b1) begin
      k++;
      @(posedge hclk);
    end
  endtask : wait_irq

  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [2:0] s, input logic p, input logic o,
    input logic e);
    return {24'h0, o, p, s, m, e};
  endfunction : cfg

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("ctrl rst", off_ctrl, 32'h0);
    rd_chk("count rst", off_count, {16'h0, count_reset});
    rd_chk("reload rst", off_reload, {16'h0, reload_reset});
    wr(8'h14, 32'hffffffff);
    rd_chk("unmapped", 8'h14, 32'h0);
    chk("oe rst", 32'h0, {31'h0, tmr_out_oe});
    $display("test reset done");
    // a start count of 3 shortens only the first pass, so the second interval is exact
    for (int i = 0; i < 4; i++) begin
      wr(off_ctrl, cfg(mode_continuous, sl[i], 1'b0, 1'b1, 1'b0));
      wr(off_count, (rl[i] > 16'h2) ? 32'h3 : 32'h1);
      wr(off_reload, {16'h0, rl[i]});
      wr(off_ctrl, cfg(mode_continuous, sl[i], 1'b0, 1'b1, 1'b1));
      wait_irq(n);
      lvl = tmr_out;
      wait_irq(n);
      chk("period", {16'h0, rl[i]} << sl[i], n);
      chk("toggle", {31'h0, ~lvl}, {31'h0, tmr_out});
      if (i == 0) rd_chk("status", off_status, 32'h1);
    end
    $display("test continuous done");
    wr(off_ctrl, cfg(mode_one_shot, 3'h0, 1'b0, 1'b1, 1'b0));
    wr(off_count, 32'hfffe);
    wr(off_reload, 32'h1);
    n_high = 0;
    wr(off_ctrl, cfg(mode_one_shot, 3'h0, 1'b0, 1'b1, 1'b1));
    wait_irq(n);
    repeat (4) @(posedge hclk);
    chk("wrap", 32'h1, {31'h0, n < 12});
    chk("pulse", 32'h1, n_high);
    rd_chk("oneshot count", off_count, {16'h0, count_restart});
    rd_chk("oneshot ctrl", off_ctrl, 32'h80);
    // polarity flipped after start: level must hold until time-out, then stay
    wr(off_ctrl, cfg(mode_one_shot, 3'h0, 1'b0, 1'b1, 1'b0));
    wr(off_count, 32'h1);
    wr(off_reload, 32'h20);
    wr(off_ctrl, cfg(mode_one_shot, 3'h0, 1'b0, 1'b1, 1'b1));
    wr(off_ctrl, cfg(mode_one_shot, 3'h0, 1'b1, 1'b1, 1'b1));
    repeat (2) @(posedge hclk);
    chk("held", 32'h0, {31'h0, tmr_out});
    wait_irq(n);
    repeat (2) @(posedge hclk);
    chk("permanent", 32'h1, {31'h0, tmr_out});
    chk("oe on", 32'h1, {31'h0, tmr_out_oe});
    $display("test one-shot done");
    // prescale 7 is set on purpose: counter mode must ignore it
    wr(off_ctrl, cfg(mode_counter, 3'h7, 1'b0, 1'b0, 1'b0));
    wr(off_count, 32'h1);
    wr(off_reload, 32'h64);
    wr(off_ctrl, cfg(mode_counter, 3'h7, 1'b0, 1'b0, 1'b1));
    gpio_pin_i.pulses(3);
    rd_chk("falling", off_count, 32'h4);
    wr(off_ctrl, cfg(mode_counter, 3'h7, 1'b1, 1'b1, 1'b0));
    wr(off_count, 32'h1);
    wr(off_reload, 32'h4);
    wr(off_ctrl, cfg(mode_counter, 3'h7, 1'b1, 1'b1, 1'b1));
    @(posedge hclk);
    chk("level", 32'h1, {31'h0, tmr_out});
    n_irq = 0;
    gpio_pin_i.pulses(5);
    rd_chk("rising", off_count, 32'h2);
    chk("irqs", 32'h1, n_irq);
    chk("toggled", 32'h0, {31'h0, tmr_out});
    $display("test counter done");
    test_done();
  end
endmodule : reload_timer_tb
`default_nettype wire
